// *** hdl/bsfd_pkg.sv ***
// Constants, opcodes and register map of the bit and shift datapath
package bsfd_pkg;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 8;
  localparam int IDX_W = 3;
  localparam int IO_AW = 6;
  localparam int OP_W = 5;
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam int SEL_W = 4;
  // Byte addresses of the bus registers
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_FLAGS = 8'h04;
  localparam logic [7:0] ADR_OPERAND = 8'h08;
  localparam logic [7:0] ADR_IO_SEL = 8'h0c;
  localparam logic [7:0] ADR_IO_DATA = 8'h10;
  localparam logic [7:0] ADR_STATE = 8'h14;
  // Command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_IDX_LSB = 8;
  localparam int CMD_IO_LSB = 16;
  // State word bits
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_BAD_BIT = 1;
  // Flag positions in the status flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] OPERAND_RST = 8'h00;
  // Command codes
  localparam logic [4:0] OP_IO_BIT_SET = 5'h01;
  localparam logic [4:0] OP_IO_BIT_CLEAR = 5'h02;
  localparam logic [4:0] OP_SHL = 5'h03;
  localparam logic [4:0] OP_SHR = 5'h04;
  localparam logic [4:0] OP_ROL = 5'h05;
  localparam logic [4:0] OP_ROR = 5'h06;
  localparam logic [4:0] OP_ASR = 5'h07;
  localparam logic [4:0] OP_SWAP = 5'h08;
  localparam logic [4:0] OP_BIT_RAISE = 5'h09;
  localparam logic [4:0] OP_BIT_LOWER = 5'h0a;
  localparam logic [4:0] OP_TO_T = 5'h0b;
  localparam logic [4:0] OP_FROM_T = 5'h0c;
  localparam logic [4:0] OP_C_RAISE = 5'h0d;
  localparam logic [4:0] OP_C_LOWER = 5'h0e;
  localparam logic [4:0] OP_N_RAISE = 5'h0f;
  localparam logic [4:0] OP_N_LOWER = 5'h10;
  localparam logic [4:0] OP_Z_RAISE = 5'h11;
  localparam logic [4:0] OP_Z_LOWER = 5'h12;
  localparam logic [4:0] OP_IRQ_GLOBAL = 5'h13;
  // Execution sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_IO_READ,
    ST_IO_WRITE
  } bsfd_state_t;
endpackage : bsfd_pkg

// *** hdl/bsfd_mem.sv ***
// Small I/O space memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module bsfd_mem #(
  parameter int WIDTH = 8,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  // Storage, no reset so it maps to RAM
  logic [WIDTH-1:0] mem [2**AW];

  // Write port
  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read port, old data on a same-address write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (en) begin
      rdata <= mem[raddr];
    end
  end
endmodule : bsfd_mem
`default_nettype wire

// *** hdl/bsfd_top.sv ***
// Bit, shift and flag datapath with a Wishbone register port
`timescale 1ns/1ns
`default_nettype none
module bsfd_top #(
  parameter int IO_AW = bsfd_pkg::IO_AW
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [bsfd_pkg::WB_AW-1:0] WB_ADR_I,
  input wire logic [bsfd_pkg::SEL_W-1:0] WB_SEL_I,
  input wire logic [bsfd_pkg::WB_DW-1:0] WB_DAT_I,
  output logic [bsfd_pkg::WB_DW-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic BUSY,
  output logic IRQ_ENABLE
);
  localparam int DW = bsfd_pkg::DATA_W;
  localparam int MSB = DW - 1;
  localparam int BW = bsfd_pkg::BYTE_W;
  localparam int XW = bsfd_pkg::IDX_W;
  localparam int OW = bsfd_pkg::OP_W;
  localparam int BUS_W = bsfd_pkg::WB_DW;
  // Unused bits between the index and I/O address fields
  localparam int GAP_W = bsfd_pkg::CMD_IO_LSB - bsfd_pkg::CMD_IDX_LSB - XW;

  // Merge write data into a word by byte lane
  function automatic logic [BUS_W-1:0] lane_merge(
    input logic [BUS_W-1:0] old_w,
    input logic [BUS_W-1:0] new_w,
    input logic [bsfd_pkg::SEL_W-1:0] sel
  );
    logic [BUS_W-1:0] r;
    r = old_w;
    for (int i = 0; i < bsfd_pkg::SEL_W; i++) begin
      if (sel[i]) begin
        r[i*BW +: BW] = new_w[i*BW +: BW];
      end
    end
    return r;
  endfunction : lane_merge

  // Force one bit of a byte to a value
  function automatic logic [DW-1:0] put_bit(
    input logic [DW-1:0] v,
    input logic [XW-1:0] idx,
    input logic b
  );
    logic [DW-1:0] r;
    r = v;
    r[idx] = b;
    return r;
  endfunction : put_bit

  // Codes that the sequencer accepts
  function automatic logic op_known(input logic [OW-1:0] op);
    return (op >= bsfd_pkg::OP_IO_BIT_SET) &&
           (op <= bsfd_pkg::OP_IRQ_GLOBAL);
  endfunction : op_known

  // Codes that take the I/O read-modify-write path
  function automatic logic op_is_io(input logic [OW-1:0] op);
    return (op == bsfd_pkg::OP_IO_BIT_SET) ||
           (op == bsfd_pkg::OP_IO_BIT_CLEAR);
  endfunction : op_is_io

  // Codes in the shift and rotate group
  function automatic logic op_is_shift(input logic [OW-1:0] op);
    return (op >= bsfd_pkg::OP_SHL) &&
           (op <= bsfd_pkg::OP_ASR);
  endfunction : op_is_shift

  // New flags after one register or flag command
  function automatic logic [DW-1:0] flag_update(
    input logic [OW-1:0] op,
    input logic [DW-1:0] f,
    input logic [DW-1:0] res,
    input logic cout,
    input logic [XW-1:0] idx,
    input logic [DW-1:0] opd
  );
    logic [DW-1:0] r;
    r = f;
    unique case (op)
      bsfd_pkg::OP_BIT_RAISE: r[idx] = 1'h1;
      bsfd_pkg::OP_BIT_LOWER: r[idx] = 1'h0;
      bsfd_pkg::OP_TO_T: r[bsfd_pkg::FLAG_T] = opd[idx];
      bsfd_pkg::OP_C_RAISE: r[bsfd_pkg::FLAG_C] = 1'h1;
      bsfd_pkg::OP_C_LOWER: r[bsfd_pkg::FLAG_C] = 1'h0;
      bsfd_pkg::OP_N_RAISE: r[bsfd_pkg::FLAG_N] = 1'h1;
      bsfd_pkg::OP_N_LOWER: r[bsfd_pkg::FLAG_N] = 1'h0;
      bsfd_pkg::OP_Z_RAISE: r[bsfd_pkg::FLAG_Z] = 1'h1;
      bsfd_pkg::OP_Z_LOWER: r[bsfd_pkg::FLAG_Z] = 1'h0;
      bsfd_pkg::OP_IRQ_GLOBAL: r[bsfd_pkg::FLAG_I] = 1'h1;
      // Other codes leave flags alone
      default: r = f;
    endcase
    // shift flag update
    // Done after the case, so its default cannot undo it
    if (op_is_shift(op)) begin
      r[bsfd_pkg::FLAG_Z] = (res == '0);
      r[bsfd_pkg::FLAG_C] = cout;
      r[bsfd_pkg::FLAG_N] = res[MSB];
      r[bsfd_pkg::FLAG_V] = res[MSB] ^ cout;
    end
    return r;
  endfunction : flag_update

  // Bus handshake state
  logic pend; // Request seen, answer next edge
  logic ack; // Registered acknowledge
  logic [BUS_W-1:0] dat_o; // Registered read data

  // Programmer-visible state
  logic [OW-1:0] cmd_op; // Current command code
  logic [XW-1:0] cmd_idx; // Bit index operand
  logic [IO_AW-1:0] cmd_io; // I/O address operand
  logic [DW-1:0] flags; // Status flags register
  logic [DW-1:0] operand; // Destination/source register
  logic [IO_AW-1:0] io_sel; // I/O address for bus access
  logic bad_cmd; // Last command code unknown

  // Sequencer
  bsfd_pkg::bsfd_state_t state; // Current state
  bsfd_pkg::bsfd_state_t next_state; // Next state

  // Bus decode
  wire req = WB_CYC_I & WB_STB_I;
  wire busy = (state != bsfd_pkg::ST_IDLE);
  // Stall new requests while a command runs
  wire start = req & ~pend & ~ack & ~busy;
  wire wr_fire = pend & WB_WE_I;
  wire a_cmd = (WB_ADR_I == bsfd_pkg::ADR_CMD);
  wire a_flags = (WB_ADR_I == bsfd_pkg::ADR_FLAGS);
  wire a_opd = (WB_ADR_I == bsfd_pkg::ADR_OPERAND);
  wire a_iosel = (WB_ADR_I == bsfd_pkg::ADR_IO_SEL);
  wire a_iodat = (WB_ADR_I == bsfd_pkg::ADR_IO_DATA);
  wire a_state = (WB_ADR_I == bsfd_pkg::ADR_STATE);

  // Current register words, zero above their fields
  wire [BUS_W-1:0] w_cmd = (BUS_W'({cmd_io,
    GAP_W'(0), cmd_idx}) << bsfd_pkg::CMD_IDX_LSB) |
    BUS_W'(cmd_op);
  wire [BUS_W-1:0] w_flags = BUS_W'(flags);
  wire [BUS_W-1:0] w_opd = BUS_W'(operand);
  wire [BUS_W-1:0] w_iosel = BUS_W'(io_sel);
  wire [DW-1:0] io_rdata; // I/O word read back
  wire [BUS_W-1:0] w_iodat = BUS_W'(io_rdata);
  wire [BUS_W-1:0] w_state = BUS_W'(
    {bad_cmd, busy} << bsfd_pkg::ST_BUSY_BIT);

  // Lane-merged write words
  wire [BUS_W-1:0] m_cmd = lane_merge(w_cmd, WB_DAT_I, WB_SEL_I);
  wire [BUS_W-1:0] m_flags = lane_merge(w_flags, WB_DAT_I,
    WB_SEL_I);
  wire [BUS_W-1:0] m_opd = lane_merge(w_opd, WB_DAT_I, WB_SEL_I);
  wire [BUS_W-1:0] m_iosel = lane_merge(w_iosel, WB_DAT_I,
    WB_SEL_I);
  wire [BUS_W-1:0] m_iodat = lane_merge(w_iodat, WB_DAT_I,
    WB_SEL_I);

  // Command write: the op lane launches the command
  wire [OW-1:0] new_op = m_cmd[bsfd_pkg::CMD_OP_LSB +: OW];
  wire cmd_wr = wr_fire & a_cmd & WB_SEL_I[0];
  wire cmd_go = cmd_wr & op_known(new_op);
  wire go_io = op_is_io(new_op);

  // Read mux, unmapped reads give zero
  wire [BUS_W-1:0] rd_mux =
    a_cmd ? w_cmd :
    a_flags ? w_flags :
    a_opd ? w_opd :
    a_iosel ? w_iosel :
    a_iodat ? w_iodat :
    a_state ? w_state : '0;

  // Register-group results
  wire c_in = flags[bsfd_pkg::FLAG_C];
  wire t_in = flags[bsfd_pkg::FLAG_T];
  wire [DW-1:0] r_shl = {operand[MSB-1:0], 1'h0};
  wire [DW-1:0] r_shr = {1'h0, operand[MSB:1]};
  wire [DW-1:0] r_rol = {operand[MSB-1:0], c_in};
  wire [DW-1:0] r_ror = {c_in, operand[MSB:1]};
  wire [DW-1:0] r_asr = {operand[MSB], operand[MSB:1]};
  wire [DW-1:0] r_swap = {operand[DW/2-1:0], operand[MSB:DW/2]};
  wire [DW-1:0] r_bld = put_bit(operand, cmd_idx, t_in);

  // Result select and carry out
  wire left_op = (cmd_op == bsfd_pkg::OP_SHL) ||
                 (cmd_op == bsfd_pkg::OP_ROL);
  wire cout = left_op ? operand[MSB] : operand[0];
  wire [DW-1:0] reg_res =
    (cmd_op == bsfd_pkg::OP_SHL) ? r_shl :
    (cmd_op == bsfd_pkg::OP_SHR) ? r_shr :
    (cmd_op == bsfd_pkg::OP_ROL) ? r_rol :
    (cmd_op == bsfd_pkg::OP_ROR) ? r_ror :
    (cmd_op == bsfd_pkg::OP_ASR) ? r_asr :
    (cmd_op == bsfd_pkg::OP_SWAP) ? r_swap :
    (cmd_op == bsfd_pkg::OP_FROM_T) ? r_bld : operand;
  // Only shift, swap and load write the register back
  wire reg_wb = op_is_shift(cmd_op) ||
    (cmd_op == bsfd_pkg::OP_SWAP) ||
    (cmd_op == bsfd_pkg::OP_FROM_T);
  wire [DW-1:0] flags_res = flag_update(cmd_op, flags, reg_res,
    cout, cmd_idx, operand);
  wire in_exec = (state == bsfd_pkg::ST_EXEC);

  // I/O space ports
  // selected bit forced high for set, low for clear
  wire [DW-1:0] io_mod = put_bit(io_rdata, cmd_idx,
    cmd_op == bsfd_pkg::OP_IO_BIT_SET);
  wire io_exec_wr = (state == bsfd_pkg::ST_IO_WRITE);
  wire io_bus_wr = wr_fire & a_iodat;
  wire mem_we = io_exec_wr | io_bus_wr;
  wire [IO_AW-1:0] mem_addr = busy ? cmd_io : io_sel;
  wire [DW-1:0] mem_wdata = busy ? io_mod : m_iodat[DW-1:0];

  // I/O space storage
  bsfd_mem #(
    .WIDTH(DW),
    .AW(IO_AW)
  ) u_io_space (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .en(CLK_EN),
    .we(mem_we),
    .waddr(mem_addr),
    .wdata(mem_wdata),
    .raddr(mem_addr),
    .rdata(io_rdata)
  );

  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      bsfd_pkg::ST_IDLE: begin
        if (cmd_go) begin
          next_state = go_io ? bsfd_pkg::ST_IO_READ
                             : bsfd_pkg::ST_EXEC;
        end
      end
      bsfd_pkg::ST_EXEC: next_state = bsfd_pkg::ST_IDLE;
      bsfd_pkg::ST_IO_READ: next_state = bsfd_pkg::ST_IO_WRITE;
      bsfd_pkg::ST_IO_WRITE: next_state = bsfd_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= bsfd_pkg::ST_IDLE;
    end else if (CLK_EN) begin
      state <= next_state;
    end
  end

  // Bus handshake, ack two cycles after the request
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend <= 1'h0;
      ack <= 1'h0;
      dat_o <= '0;
    end else if (CLK_EN) begin
      pend <= start;
      ack <= pend;
      // Reads only, so read data stands until the next read
      if (pend && !WB_WE_I) begin
        dat_o <= rd_mux;
      end
    end
  end

  // Command fields, only taken with the op lane
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_op <= '0;
      cmd_idx <= '0;
      cmd_io <= '0;
      bad_cmd <= 1'h0;
    end else if (CLK_EN && cmd_wr) begin
      cmd_op <= new_op;
      cmd_idx <= m_cmd[bsfd_pkg::CMD_IDX_LSB +: XW];
      cmd_io <= m_cmd[bsfd_pkg::CMD_IO_LSB +: IO_AW];
      bad_cmd <= ~op_known(new_op);
    end
  end

  // Status flags: bus write or execute cycle
  // I/O commands leave flags
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags <= bsfd_pkg::FLAGS_RST;
    end else if (CLK_EN && in_exec) begin
      flags <= flags_res;
    end else if (CLK_EN && wr_fire && a_flags) begin
      flags <= m_flags[DW-1:0];
    end
  end

  // Operand register, written back by execute
  // source kept by bit store
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      operand <= bsfd_pkg::OPERAND_RST;
    end else if (CLK_EN && in_exec && reg_wb) begin
      operand <= reg_res;
    end else if (CLK_EN && wr_fire && a_opd) begin
      operand <= m_opd[DW-1:0];
    end
  end

  // I/O address used by bus accesses
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      io_sel <= '0;
    end else if (CLK_EN && wr_fire && a_iosel) begin
      io_sel <= m_iosel[IO_AW-1:0];
    end
  end

  // Outputs
  assign WB_ACK_O = ack;
  assign WB_DAT_O = dat_o;
  assign BUSY = busy;
  assign IRQ_ENABLE = flags[bsfd_pkg::FLAG_I];
endmodule : bsfd_top
`default_nettype wire

// *** dv/bsfd_top_properties.sv ***
// Port checker for the bit and shift datapath
`timescale 1ns/1ns
`default_nettype none
module bsfd_top_properties (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [bsfd_pkg::WB_AW-1:0] WB_ADR_I,
  input wire logic [bsfd_pkg::SEL_W-1:0] WB_SEL_I,
  input wire logic [bsfd_pkg::WB_DW-1:0] WB_DAT_I,
  input wire logic [bsfd_pkg::WB_DW-1:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic BUSY,
  input wire logic IRQ_ENABLE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // Command write seen in its answer cycle
  wire logic cmd_ack = WB_ACK_O && WB_WE_I && WB_SEL_I[0]
    && WB_ADR_I == bsfd_pkg::ADR_CMD;
  wire logic [4:0] op = WB_DAT_I[4:0];
  // Unknown codes are left out on purpose
  wire logic io_op = op == bsfd_pkg::OP_IO_BIT_SET
    || op == bsfd_pkg::OP_IO_BIT_CLEAR;
  wire logic reg_op = op >= bsfd_pkg::OP_SHL
    && op <= bsfd_pkg::OP_IRQ_GLOBAL;
  AST_IO_BUSY: assert property (
    cmd_ack && io_op |-> BUSY ##1 BUSY ##1 !BUSY)
    else $error("io command busy length wrong");
  AST_REG_BUSY: assert property (
    cmd_ack && reg_op |-> BUSY ##1 !BUSY)
    else $error("register command busy length wrong");
  AST_IRQ_CMD: assert property (
    cmd_ack && op == bsfd_pkg::OP_IRQ_GLOBAL |-> ##2 IRQ_ENABLE)
    else $error("interrupt enable not raised");
  AST_IRQ_CAUSE: assert property (
    $changed(IRQ_ENABLE) |-> WB_ACK_O || $past(WB_ACK_O))
    else $error("interrupt enable changed without access");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  AST_ACK_TIME: assert property ($rose(WB_CYC_I && WB_STB_I) && !BUSY
    && CLK_EN ##1 CLK_EN |=> WB_ACK_O)
    else $error("ack not in cycle two");
  AST_NO_SPUR: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
    else $error("ack without request");
  AST_FREEZE: assert property (!CLK_EN |=> $stable(WB_ACK_O)
    && $stable(BUSY) && $stable(IRQ_ENABLE))
    else $error("state moved while clock enable low");
  AST_RST_OUT: assert property ($rose(RST_N) |->
    !WB_ACK_O && !BUSY && !IRQ_ENABLE)
    else $error("outputs not cleared after reset");
  AST_DAT_HOLD: assert property (
    $changed(WB_DAT_O) |-> WB_ACK_O && !WB_WE_I)
    else $error("read data changed outside read answer");
endmodule : bsfd_top_properties
bind bsfd_top bsfd_top_properties bsfd_top_properties_inst (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .BUSY(BUSY),
  .IRQ_ENABLE(IRQ_ENABLE));
`default_nettype wire

// *** dv/bsfd_top_tb_top.sv ***
// Self-checking bench for the bit and shift datapath
`timescale 1ns/1ns
`default_nettype none
module bsfd_top_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0;
  wire logic [31:0] dat_o;
  wire logic ack;
  wire logic busy;
  wire logic irq_en;
  int mismatches = 0;
  int samples_checked = 0;
  // Last read data taken at the ack edge
  logic [31:0] rd;
  // 10 MHz core clock
  always #50 clk = ~clk;
  bsfd_top bsfd_top_inst (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .BUSY(busy), .IRQ_ENABLE(irq_en));
  // Verdict and end of run
  task automatic complete_run;
    $display("mismatches %0d samples %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for ack, then release; ack read before its edge lands
  task automatic wb_wait;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      mismatches++;
      complete_run();
    end
  endtask : wb_wait
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [3:0] s, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wd <= d;
    wb_wait();
  endtask : wb
  // Load operand and flags, launch, read both back
  task automatic run_op(input logic [4:0] op, input logic [2:0] ix,
      input logic [5:0] io, input logic [7:0] v, input logic [7:0] f,
      input logic [7:0] ev, input logic [7:0] ef);
    wb(1'b1, bsfd_pkg::ADR_OPERAND, 4'h1, {24'h0, v});
    wb(1'b1, bsfd_pkg::ADR_FLAGS, 4'h1, {24'h0, f});
    wb(1'b1, bsfd_pkg::ADR_CMD, 4'h7, {10'h0, io, 5'h0, ix, 3'h0, op});
    wb(1'b0, bsfd_pkg::ADR_OPERAND, 4'hf, 32'h0);
    chk(rd, {24'h0, ev});
    wb(1'b0, bsfd_pkg::ADR_FLAGS, 4'hf, 32'h0);
    chk(rd, {24'h0, ef});
  endtask : run_op
  // Expected {flags, result}; V is N xor C, S H T I kept
  function automatic logic [15:0] model(input logic [4:0] op,
      input logic [7:0] v, input logic [7:0] f);
    logic [7:0] r;
    logic c;
    c = (op == bsfd_pkg::OP_SHL || op == bsfd_pkg::OP_ROL) ? v[7] : v[0];
    case (op)
      bsfd_pkg::OP_SHL: r = {v[6:0], 1'b0};
      bsfd_pkg::OP_SHR: r = {1'b0, v[7:1]};
      bsfd_pkg::OP_ROL: r = {v[6:0], f[0]};
      bsfd_pkg::OP_ROR: r = {f[0], v[7:1]};
      default: r = {v[7], v[7:1]};
    endcase
    return {f[7:4], r[7] ^ c, r[7], r == 8'h00, c, r};
  endfunction : model
  task automatic sc_reset;
    wb(1'b0, bsfd_pkg::ADR_FLAGS, 4'hf, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, bsfd_pkg::ADR_OPERAND, 4'hf, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq_en}, 32'h0);
  endtask : sc_reset
  // Each shift code, carry in set and clear, zero result too
  task automatic sc_shifts;
    logic [15:0] e;
    logic [7:0] v;
    logic [7:0] f;
    for (int o = bsfd_pkg::OP_SHL; o <= bsfd_pkg::OP_ASR; o++) begin
      for (int k = 0; k < 2; k++) begin
        v = k ? 8'h01 : 8'h81;
        f = k ? 8'h00 : 8'h71;
        e = model(o[4:0], v, f);
        run_op(o[4:0], 3'h0, 6'h0, v, f, e[7:0], e[15:8]);
      end
    end
    run_op(bsfd_pkg::OP_SWAP, 3'h0, 6'h0, 8'ha5, 8'h5f, 8'h5a, 8'h5f);
  endtask : sc_shifts
  // Every flag index raised then lowered, transfer flag both ways
  task automatic sc_flags;
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      run_op(bsfd_pkg::OP_BIT_RAISE, i[2:0], 6'h0, 8'h42, 8'h00, 8'h42, m);
      run_op(bsfd_pkg::OP_BIT_LOWER, i[2:0], 6'h0, 8'h42, 8'hff, 8'h42, ~m);
    end
    run_op(bsfd_pkg::OP_TO_T, 3'h4, 6'h0, 8'h10, 8'h00, 8'h10, 8'h40);
    run_op(bsfd_pkg::OP_FROM_T, 3'h7, 6'h0, 8'h00, 8'h40, 8'h80, 8'h40);
    run_op(bsfd_pkg::OP_FROM_T, 3'h3, 6'h0, 8'hff, 8'h00, 8'hf7, 8'h00);
  endtask : sc_flags
  // Dedicated codes in order C, N, Z then I
  task automatic sc_dedic;
    logic [7:0] m;
    logic [7:0] f;
    for (int o = bsfd_pkg::OP_C_RAISE; o <= bsfd_pkg::OP_IRQ_GLOBAL; o++) begin
      m = o < 15 ? 8'h01 : o < 17 ? 8'h04 : o < 19 ? 8'h02 : 8'h80;
      f = o[0] ? 8'h00 : 8'hff;
      run_op(o[4:0], 3'h0, 6'h0, 8'h33, f, 8'h33, o[0] ? m : ~m);
    end
    chk({31'h0, irq_en}, 32'h1);
  endtask : sc_dedic
  // Top I/O address, bit 7 set then bit 3 cleared
  task automatic sc_io;
    wb(1'b1, bsfd_pkg::ADR_IO_SEL, 4'h1, 32'h3f);
    wb(1'b1, bsfd_pkg::ADR_IO_DATA, 4'h1, 32'h5a);
    run_op(bsfd_pkg::OP_IO_BIT_SET, 3'h7, 6'h3f, 8'h11, 8'h3c, 8'h11, 8'h3c);
    wb(1'b0, bsfd_pkg::ADR_IO_DATA, 4'hf, 32'h0);
    chk(rd, 32'hda);
    run_op(bsfd_pkg::OP_IO_BIT_CLEAR, 3'h3, 6'h3f, 8'h11, 8'h3c, 8'h11, 8'h3c);
    wb(1'b0, bsfd_pkg::ADR_IO_DATA, 4'hf, 32'h0);
    chk(rd, 32'hd2);
    wb(1'b0, bsfd_pkg::ADR_CMD, 4'hf, 32'h0);
    chk(rd, 32'h003f0302);
  endtask : sc_io
  // Unmapped place, lane without SEL[0], unknown code, frozen clock
  task automatic sc_refuse;
    wb(1'b1, 8'h40, 4'hf, 32'hffffffff);
    wb(1'b0, 8'h40, 4'hf, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, bsfd_pkg::ADR_CMD, 4'h2, {27'h0, bsfd_pkg::OP_SHL});
    wb(1'b1, bsfd_pkg::ADR_CMD, 4'h1, 32'h1f);
    wb(1'b0, bsfd_pkg::ADR_STATE, 4'hf, 32'h0);
    chk(rd, 32'h2);
    wb(1'b0, bsfd_pkg::ADR_OPERAND, 4'hf, 32'h0);
    chk(rd, 32'h11);
    wb(1'b1, bsfd_pkg::ADR_FLAGS, 4'h2, 32'hffffffff);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b0;
    adr <= bsfd_pkg::ADR_FLAGS;
    clk_en <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      chk({31'h0, ack}, 32'h0);
    end
    clk_en <= 1'b1;
    wb_wait();
    chk(rd, 32'h3c);
  endtask : sc_refuse
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    sc_reset();
    sc_shifts();
    sc_flags();
    sc_dedic();
    sc_io();
    sc_refuse();
    complete_run();
  end
endmodule : bsfd_top_tb_top
`default_nettype wire
